// ### rtl/ohvm_pkg.sv
// Purpose: constants and types for the odd half-word vector multiply datapath
// Assumes: little-endian bit numbering in the instruction word (bit 31 is the msb)
package ohvm_pkg;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam logic [5:0]  PRIMARY_OP     = 6'h04;
  localparam logic [10:0] XO_SMI         = 11'h46B;
  localparam logic [10:0] XO_SMIA        = 11'h46B;
  localparam logic [10:0] XO_SMIAAW      = 11'h50D;
  localparam logic [10:0] XO_SMIANW      = 11'h58D;
  localparam logic [10:0] XO_SSF         = 11'h407;
  localparam logic [10:0] XO_SSFA        = 11'h427;
  localparam logic [10:0] XO_SSFAAW      = 11'h507;
  localparam logic [10:0] XO_SMI_PLAIN   = 11'h40C;
  localparam logic [10:0] XO_SMIA_ACC    = 11'h42C;

  // ----------------------------------------------------------------
  // lane constants
  // ----------------------------------------------------------------
  localparam logic [31:0] SAT_POS        = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG        = 32'h8000_0000;
  localparam logic [63:0] ACC_RESET      = 64'h0000_0000_0000_0000;

  typedef enum logic [7:0] {
    OHVM_OP_NONE   = 8'b0000_0001,
    OHVM_OP_MI     = 8'b0000_0010,
    OHVM_OP_MIA    = 8'b0000_0100,
    OHVM_OP_MIAAW  = 8'b0000_1000,
    OHVM_OP_MIANW  = 8'b0001_0000,
    OHVM_OP_SF     = 8'b0010_0000,
    OHVM_OP_SFA    = 8'b0100_0000,
    OHVM_OP_SFAAW  = 8'b1000_0000
  } ohvm_op_e;

  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [63:0] src_a;
    logic [63:0] src_b;
  } ohvm_req_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  rd;
    logic [63:0] data;
    logic        acc_we;
  } ohvm_res_s;

  typedef struct packed {
    logic upper_lane_overflow;
    logic lower_lane_overflow;
    logic upper_lane_sticky_overflow;
    logic lower_lane_sticky_overflow;
  } ohvm_stat_s;

endpackage

// ### rtl/ohvm_lane.sv
// Purpose: one word lane of the odd half-word multiply
// Assumes: operands already selected as signed half-words
// Notes:   purely combinational
`timescale 1ns/1ns
module ohvm_lane (
  input  wire logic                 [15:0] half_a,
  input  wire logic                 [15:0] half_b,
  input  wire logic                 [31:0] acc_word,
  input  wire ohvm_pkg::ohvm_op_e          op,
  output logic                      [31:0] result,
  output logic                             ovf
);
  import ohvm_pkg::*;

  // ----------------------------------------------------------------
  // products
  // ----------------------------------------------------------------
  wire logic signed [31:0] prod    = 32'($signed(half_a)) * 32'($signed(half_b));
  wire logic        [32:0] frac    = {prod, 1'b0};
  wire logic               movf    = frac[32] ^ frac[31];
  wire logic        [31:0] frac_s  = movf ? SAT_POS : frac[31:0];
  wire logic        [32:0] m_sum   = {1'b0, acc_word} + {1'b0, prod};
  wire logic        [32:0] m_dif   = {1'b0, acc_word} - {1'b0, prod};
  wire logic        [32:0] s_sum   = {acc_word[31], acc_word} + {frac_s[31], frac_s};
  wire logic               aovf    = s_sum[32] ^ s_sum[31];
  wire logic        [31:0] s_clamp = aovf ? (s_sum[32] ? SAT_NEG : SAT_POS)
                                          : s_sum[31:0];

  always_comb begin
    result = prod;
    ovf    = 1'b0;
    unique case (op)
      OHVM_OP_MIAAW: result = m_sum[31:0];
      OHVM_OP_MIANW: result = m_dif[31:0];
      OHVM_OP_SF, OHVM_OP_SFA: begin
        result = frac_s;
        ovf    = movf;
      end
      OHVM_OP_SFAAW: begin
        result = s_clamp;
        ovf    = movf | aovf;
      end
      default: result = prod;
    endcase
  end

endmodule // ohvm_lane

// ### rtl/ohvm_top.sv
// Purpose: odd half-word vector multiply datapath, one result per request with a listed opcode
// Assumes: pipeline presents one request per cycle, operands already read
// Notes:   result and status registered, one cycle latency
`timescale 1ns/1ns
module ohvm_top (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire ohvm_pkg::ohvm_req_s  req,
  output ohvm_pkg::ohvm_res_s       res,
  output logic               [63:0] accumulator_reg,
  output ohvm_pkg::ohvm_stat_s      vector_status_control_reg
);
  import ohvm_pkg::*;

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // extended opcode to one-hot operation, none when unlisted
  function automatic ohvm_op_e decode_xo(input logic [10:0] xo);
    ohvm_op_e op_v;
    op_v = OHVM_OP_NONE;
    unique case (xo)
      XO_SMI_PLAIN: op_v = OHVM_OP_MI;
      XO_SMIA_ACC:  op_v = OHVM_OP_MIA;
      XO_SMIAAW:    op_v = OHVM_OP_MIAAW;
      XO_SMIANW:    op_v = OHVM_OP_MIANW;
      XO_SSF:       op_v = OHVM_OP_SF;
      XO_SSFA:      op_v = OHVM_OP_SFA;
      XO_SSFAAW:    op_v = OHVM_OP_SFAAW;
      default:      op_v = OHVM_OP_NONE;
    endcase
    return op_v;
  endfunction

  // odd half-word of the upper word lane
  function automatic logic [15:0] odd_half_upper(input logic [63:0] v);
    return v[47:32];
  endfunction

  // odd half-word of the lower word lane
  function automatic logic [15:0] odd_half_lower(input logic [63:0] v);
    return v[15:0];
  endfunction

  // forms that copy their result into the accumulator
  function automatic logic writes_acc(input ohvm_op_e op_v);
    logic we_v;
    we_v = 1'b0;
    unique case (op_v)
      OHVM_OP_MIA,
      OHVM_OP_MIAAW,
      OHVM_OP_MIANW,
      OHVM_OP_SFA,
      OHVM_OP_SFAAW: we_v = 1'b1;
      default:       we_v = 1'b0;
    endcase
    return we_v;
  endfunction

  // forms that update the overflow status
  function automatic logic is_saturating(input ohvm_op_e op_v);
    logic sat_v;
    sat_v = 1'b0;
    unique case (op_v)
      OHVM_OP_SF,
      OHVM_OP_SFA,
      OHVM_OP_SFAAW: sat_v = 1'b1;
      default:       sat_v = 1'b0;
    endcase
    return sat_v;
  endfunction

  // ----------------------------------------------------------------
  // registers and their next values
  // ----------------------------------------------------------------
  ohvm_res_s   res_ff;
  ohvm_res_s   nxt_res;
  logic [63:0] acc_ff;
  logic [63:0] nxt_acc;
  ohvm_stat_s  stat_ff;
  ohvm_stat_s  nxt_stat;

  // ----------------------------------------------------------------
  // request fields
  // ----------------------------------------------------------------
  wire logic [63:0] src_a  = req.src_a;
  wire logic [63:0] src_b  = req.src_b;

  // ----------------------------------------------------------------
  // instruction decode
  // ----------------------------------------------------------------
  wire logic [5:0]  f_prim = req.instr[31:26];
  wire logic [4:0]  f_rd   = req.instr[25:21];
  wire logic [10:0] f_xo   = req.instr[10:0];
  wire logic        hit    = req.valid && (f_prim == PRIMARY_OP);

  // unlisted or foreign opcode decodes as none
  ohvm_op_e op;
  always_comb begin
    op = OHVM_OP_NONE;
    if (hit) begin
      op = decode_xo(f_xo);
    end
  end

  // ----------------------------------------------------------------
  // operand selection
  // ----------------------------------------------------------------
  wire logic [15:0] up_half_a = odd_half_upper(src_a);
  wire logic [15:0] up_half_b = odd_half_upper(src_b);
  wire logic [15:0] lo_half_a = odd_half_lower(src_a);
  wire logic [15:0] lo_half_b = odd_half_lower(src_b);
  wire logic [31:0] up_acc_wd = acc_ff[63:32];
  wire logic [31:0] lo_acc_wd = acc_ff[31:0];

  // ----------------------------------------------------------------
  // lanes
  // ----------------------------------------------------------------
  logic [31:0] up_res;
  logic [31:0] lo_res;
  logic        up_ovf;
  logic        lo_ovf;

  // upper word lane
  ohvm_lane u_upper (
    .half_a   (up_half_a),
    .half_b   (up_half_b),
    .acc_word (up_acc_wd),
    .op       (op),
    .result   (up_res),
    .ovf      (up_ovf)
  );

  // lower word lane
  ohvm_lane u_lower (
    .half_a   (lo_half_a),
    .half_b   (lo_half_b),
    .acc_word (lo_acc_wd),
    .op       (op),
    .result   (lo_res),
    .ovf      (lo_ovf)
  );

  // ----------------------------------------------------------------
  // write control
  // ----------------------------------------------------------------
  wire logic        known  = (op != OHVM_OP_NONE);
  wire logic        acc_we = writes_acc(op);
  wire logic        sat_op = is_saturating(op);
  wire logic [63:0] dval   = {up_res, lo_res};

  // ----------------------------------------------------------------
  // status next value
  // ----------------------------------------------------------------
  // modulo forms leave the status alone
  wire logic nxt_up_ovf = sat_op ? up_ovf : stat_ff.upper_lane_overflow;
  wire logic nxt_lo_ovf = sat_op ? lo_ovf : stat_ff.lower_lane_overflow;
  // sticky bits only ever set here
  wire logic nxt_up_sticky = stat_ff.upper_lane_sticky_overflow | (sat_op & up_ovf);
  wire logic nxt_lo_sticky = stat_ff.lower_lane_sticky_overflow | (sat_op & lo_ovf);

  always_comb begin
    nxt_stat                            = '0;
    nxt_stat.upper_lane_overflow        = nxt_up_ovf;
    nxt_stat.lower_lane_overflow        = nxt_lo_ovf;
    nxt_stat.upper_lane_sticky_overflow = nxt_up_sticky;
    nxt_stat.lower_lane_sticky_overflow = nxt_lo_sticky;
  end

  // ----------------------------------------------------------------
  // answer next value
  // ----------------------------------------------------------------
  always_comb begin
    nxt_res        = '0;
    nxt_res.valid  = known;
    nxt_res.rd     = f_rd;
    nxt_res.data   = dval;
    nxt_res.acc_we = acc_we;
  end

  // ----------------------------------------------------------------
  // accumulator next value
  // ----------------------------------------------------------------
  // holds unless the form writes it
  always_comb begin
    nxt_acc = acc_ff;
    if (acc_we) begin
      nxt_acc = dval;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      res_ff <= '0;
    end else begin
      res_ff <= nxt_res;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      acc_ff <= ACC_RESET;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // straight from the registers
  assign res                       = res_ff;
  assign accumulator_reg           = acc_ff;
  assign vector_status_control_reg = stat_ff;

endmodule // ohvm_top

// ### test/ohvm_asserts.sv
// Purpose: port checks for ohvm_top
// Assumes: answer one cycle after request
// Notes: bound at foot
`timescale 1ns/1ns
module ohvm_chk (
  input wire logic clk,
  input wire logic reset,
  input wire ohvm_pkg::ohvm_req_s req,
  input wire ohvm_pkg::ohvm_res_s res,
  input wire logic [63:0] accumulator_reg,
  input wire ohvm_pkg::ohvm_stat_s vector_status_control_reg
);
  import ohvm_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic [10:0] x = req.instr[10:0];
  wire logic g = req.valid && req.instr[31:26] == PRIMARY_OP;
  wire logic m = g && x inside {XO_SMI_PLAIN, XO_SMIA_ACC, XO_SMIAAW, XO_SMIANW};
  wire logic s = g && x inside {XO_SSF, XO_SSFA, XO_SSFAAW};
  wire logic [3:0] st = vector_status_control_reg;
  wire logic n1 = req.src_a[15:0] == 16'h8000 && req.src_b[15:0] == 16'h8000;
  chk_ans_lat: assert property (m || s |=> res.valid && res.rd == $past(req.instr[25:21]))
    else $error("no answer");
  chk_no_ans: assert property (!(m || s) |=> !res.valid) else $error("spurious answer");
  chk_acc_keep: assert property (g && x == XO_SMI_PLAIN |=> $stable(accumulator_reg))
    else $error("acc moved");
  chk_acc_copy: assert property ((m || s) && x != XO_SMI_PLAIN && x != XO_SSF
    |=> accumulator_reg == res.data) else $error("acc copy");
  chk_mod_stat: assert property (m |=> $stable(st)) else $error("status moved");
  chk_sat_ovf: assert property (s && n1 |=> st[2]) else $error("no ovf");
  chk_sat_val: assert property (g && x == XO_SSF && n1 |=> res.data[31:0] == SAT_POS)
    else $error("no clamp");
  chk_sticky_or: assert property (s |=> st[1:0] == ($past(st[1:0]) | st[3:2]))
    else $error("sticky");
  cover property (s && n1);
  cover property (m ##1 m);
  cover property (req.valid && !(m || s));
endmodule // ohvm_chk
bind ohvm_top ohvm_chk chk_u (.clk(clk), .reset(reset), .req(req), .res(res),
  .accumulator_reg(accumulator_reg), .vector_status_control_reg(vector_status_control_reg));

// ### test/ohvm_pipe_model.sv
// Purpose: pipeline model that presents requests
// Assumes: called at the falling edge
// Notes: idle request shows inverted last fields
`timescale 1ns/1ns
module ohvm_pipe_model (
  output ohvm_pkg::ohvm_req_s req
);
  import ohvm_pkg::*;
  initial req = '0;
  task automatic send(input logic v, input logic [10:0] xo,
                      input logic [63:0] a, input logic [63:0] b);
    if (v) req = '{1'b1, {PRIMARY_OP, a[20:6], xo}, a, b};
    else req = '{1'b0, ~req.instr, ~req.src_a, ~req.src_b};
  endtask
endmodule // ohvm_pipe_model

// ### test/odd_halfword_vector_multiply_tb.sv
// Purpose: self-checking bench for ohvm_top
// Assumes: answer one cycle after request, seed 68
// Notes: expected lanes from a bench function
`timescale 1ns/1ns
module odd_halfword_vector_multiply_tb;
  import ohvm_pkg::*;
  logic clk = 0, reset = 1, v_x = 0, we_x = 0;
  ohvm_req_s req;
  ohvm_res_s res;
  ohvm_stat_s st;
  logic [63:0] acc, acc_x = 0, dat_x = 0;
  logic [3:0] st_x = 0;
  int err_count = 0, samples_checked = 0;
  integer seed = 68;
  logic [10:0] ops [8] = '{XO_SMI_PLAIN, XO_SMIA_ACC, XO_SMIAAW, XO_SMIANW,
                           XO_SSF, XO_SSFA, XO_SSFAAW, 11'h7FF};
  always #20 clk = ~clk;
  ohvm_pipe_model pipe_u (.req(req));
  ohvm_top dut_u (.clk(clk), .reset(reset), .req(req), .res(res),
    .accumulator_reg(acc), .vector_status_control_reg(st));
  function automatic logic [32:0] lane(int k, logic [15:0] a, logic [15:0] b, logic [31:0] w);
    logic signed [31:0] p;
    logic [32:0] t;
    logic m;
    p = $signed(a) * $signed(b);
    m = k > 3 && p[31] != p[30];
    if (k > 3) p = m ? SAT_POS : {p[30:0], 1'b0};
    if (k == 2 || k == 6) t = {w[31], w} + {p[31], p};
    else if (k == 3) t = {w[31], w} - {p[31], p};
    else return {m, p};
    if (k == 6 && t[32] != t[31]) return {1'b1, t[32] ? SAT_NEG : SAT_POS};
    return {m, t[31:0]};
  endfunction
  task automatic check(logic [63:0] got, logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic issue(int k, logic [63:0] a, logic [63:0] b);
    logic [32:0] hi, lo;
    @(negedge clk);
    check(res.valid, v_x);
    if (v_x) check(res.data, dat_x);
    check(acc, acc_x);
    check(res.acc_we, we_x);
    check(st, st_x);
    hi = lane(k, a[47:32], b[47:32], acc_x[63:32]);
    lo = lane(k, a[15:0], b[15:0], acc_x[31:0]);
    v_x = k < 7;
    we_x = k inside {1, 2, 3, 5, 6};
    pipe_u.send(k < 8, ops[k % 8], a, b);
    dat_x = {hi[31:0], lo[31:0]};
    if (k inside {1, 2, 3, 5, 6}) acc_x = dat_x;
    if (k inside {4, 5, 6}) st_x = {hi[32], lo[32], st_x[1:0] | {hi[32], lo[32]}};
  endtask
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    issue(8, 0, 0);
    for (int k = 0; k < 8; k++) issue(k, {4{16'h8000}}, {4{16'h8000}});
    repeat (4) issue(6, {4{16'h8000}}, {4{16'h7FFF}});
    repeat (4) issue(6, {4{16'h8000}}, {4{16'h8000}});
    repeat (500) issue($unsigned($random(seed)) % 9, {$random(seed), $random(seed)},
      {$random(seed), $random(seed)});
    issue(8, 0, 0);
    wrap_up();
  end
endmodule // odd_halfword_vector_multiply_tb
